// ---- core/hvb_consts.svh ----
// constants for the high-voltage pin interrupt enable bank
// assumes: included by bare name from the package and the design modules
`ifndef HVB_CONSTS_SVH
`define HVB_CONSTS_SVH

// ****************************************
// register addresses (7-bit serial address)
// ****************************************
`define HVB_ADDR_B0_EDGE_EN 7'h37
`define HVB_ADDR_B0_FAULT_EN 7'h38
`define HVB_ADDR_B1_EDGE_EN 7'h47
`define HVB_ADDR_B1_FAULT_EN 7'h48
`define HVB_ADDR_B0_EDGE_PEND 7'h64
`define HVB_ADDR_B0_FAULT_PEND 7'h65
`define HVB_ADDR_B1_EDGE_PEND 7'h66
`define HVB_ADDR_B1_FAULT_PEND 7'h67

// ****************************************
// reset and mode defaults
// ****************************************
`define HVB_EN_RESET 8'h00
`define HVB_PEND_RESET 8'h00
`define HVB_FSP_EDGE_EN 8'hAA
`define HVB_FSP_FAULT_EN 8'h00
`define HVB_UNMAPPED_READ 8'h00

// ****************************************
// serial frame layout
// ****************************************
`define HVB_FRAME_BITS 5'd16
`define HVB_HDR_BITS 5'd8
`define HVB_HDR_LAST 5'd7
`define HVB_CNT_SAT 5'd17
`define HVB_RO_BIT 8
`define HVB_ADDR_MSB 15
`define HVB_ADDR_LSB 9

`endif

// ---- core/hvb_pkg.sv ----
// types shared by the pin interrupt enable bank and its serial port
// assumes: hvb_consts.svh is on the include path
package hvb_pkg;
  `include "hvb_consts.svh"

  // ****************************************
  // operating modes announced on entry
  // ****************************************
  typedef enum logic [2:0] {
    mode_off,
    mode_forced_normal,
    mode_standby,
    mode_normal,
    mode_sleep,
    mode_reset,
    mode_overload,
    mode_fsp
  } hvb_mode_t;

  // ****************************************
  // one-cycle event pulses, laid out as the registers
  // ****************************************
  typedef struct packed {
    logic [7:0] b0_transition;
    logic [7:0] b0_fault;
    logic [7:0] b1_transition;
    logic [7:0] b1_fault;
  } hvb_pin_events_t;

  // ****************************************
  // completed serial write
  // ****************************************
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } hvb_spi_req_t;
endpackage : hvb_pkg

// ---- core/hvb_spi_slave.sv ----
// serial peripheral slave: 16-bit frames, address, read-only flag, data
// assumes: sck idle low, sdi sampled on sck fall, sdo changes on sck rise
`timescale 1ns/10ps
`include "hvb_consts.svh"
module hvb_spi_slave import hvb_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pins
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // register side
  output logic [6:0] rd_addr,
  input wire logic [7:0] rd_data,
  output hvb_spi_req_t wr_req
);
  logic sck_s1, sck_s2, sck_d;
  logic cs_n_s1, cs_n_s2, cs_n_d;
  logic sdi_s1, sdi_s2;
  logic [4:0] bit_cnt;
  logic [15:0] rx_sr;
  logic [7:0] rd_latch;
  logic sck_rise, sck_fall, frame_start, frame_end, cs_active;

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {sck_s1, sck_s2, sck_d} <= 3'h0;
      {cs_n_s1, cs_n_s2, cs_n_d} <= 3'h7;
      {sdi_s1, sdi_s2} <= 2'h0;
    end else begin
      {sck_s1, sck_s2, sck_d} <= {spi_sck, sck_s1, sck_s2};
      {cs_n_s1, cs_n_s2, cs_n_d} <= {spi_cs_n, cs_n_s1, cs_n_s2};
      {sdi_s1, sdi_s2} <= {spi_sdi, sdi_s1};
    end
  end

  assign cs_active = ~cs_n_s2;
  assign sck_rise = sck_s2 & ~sck_d & cs_active;
  assign sck_fall = ~sck_s2 & sck_d & cs_active;
  assign frame_start = cs_n_d & ~cs_n_s2;
  assign frame_end = ~cs_n_d & cs_n_s2;
  assign spi_sdo_oe = cs_active;
  assign rd_addr = rx_sr[6:0];

  // ****************************************
  // receive side
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst || frame_start) begin
      bit_cnt <= 5'h0;
      rx_sr <= 16'h0000;
    end else if (sck_fall) begin
      rx_sr <= {rx_sr[14:0], sdi_s2};
      // count saturates so overlong frames are rejected at the end
      if (bit_cnt != `HVB_CNT_SAT) begin
        bit_cnt <= bit_cnt + 5'h1;
      end
    end
  end

  // ****************************************
  // transmit side: zeros in the header, register data after it
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst || frame_start) begin
      rd_latch <= 8'h00;
    end else if (sck_fall && bit_cnt == `HVB_HDR_LAST) begin
      rd_latch <= rd_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || frame_start) begin
      spi_sdo <= 1'b0;
    end else if (sck_rise) begin
      if (bit_cnt >= `HVB_HDR_BITS && bit_cnt < `HVB_FRAME_BITS) begin
        spi_sdo <= rd_latch[3'(5'd15 - bit_cnt)];
      end else begin
        spi_sdo <= 1'b0;
      end
    end
  end

  // ****************************************
  // write commit: only a whole 16-bit frame with read-only clear
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_req <= '0;
    end else begin
      wr_req.wr <= frame_end && bit_cnt == `HVB_FRAME_BITS && !rx_sr[`HVB_RO_BIT];
      wr_req.addr <= rx_sr[`HVB_ADDR_MSB:`HVB_ADDR_LSB];
      wr_req.data <= rx_sr[7:0];
    end
  end
endmodule : hvb_spi_slave

// ---- core/hvb_irq_enable_bank.sv ----
// interrupt enable and pending bank for eight high-voltage pins in two banks
// assumes: event pulses come from logic on clk; mode entry is a one-cycle pulse
//
// Notes on behaviour
// - register 37h enables falling (odd bit) and rising (even bit) edge events of pins 4..1.
// - register 38h enables short (odd bit) and open-load (even bit) faults of pins 4..1.
// - register 47h is the edge enable for pins 8..5 with the bank-0 layout.
// - register 48h is the fault enable for pins 8..5 with the bank-0 layout.
// - every enable bit reads back what was written; one lets its event interrupt, zero blocks it.
// - entering off or fail-safe mode reloads the enable and pending bits with that mode's defaults; other modes keep them.
// - registers 64h..67h hold pending flags in the same layouts as the enables.
`timescale 1ns/10ps
`include "hvb_consts.svh"
module hvb_irq_enable_bank import hvb_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial port pins
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // mode control
  input wire logic mode_enter,
  input wire hvb_mode_t mode_sel,
  // pin event pulses
  input wire hvb_pin_events_t pin_events,
  // interrupt
  output logic irq_req,
  output logic [31:0] irq_active_vec
);
  localparam int NREG = 4;

  logic [7:0] en_reg [0:NREG-1];
  logic [7:0] pend_reg [0:NREG-1];
  logic [7:0] pend_next [0:NREG-1];
  logic [7:0] ev [0:NREG-1];
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  hvb_spi_req_t wr_req;
  logic mode_clear;
  logic irq_next;
  logic [31:0] active_next;
  logic [2:0] wr_en_dec;
  logic [2:0] wr_pend_dec;
  logic [2:0] rd_en_dec;
  logic [2:0] rd_pend_dec;
  logic en_wr_hit;
  logic wr_pend_hit;
  logic [7:0] clr_mask [0:NREG-1];

  // ****************************************
  // address decoding
  // ****************************************
  // returns {hit, index} for an enable register address
  function automatic logic [2:0] en_decode(input logic [6:0] addr);
    case (addr)
      `HVB_ADDR_B0_EDGE_EN: en_decode = 3'h4;
      `HVB_ADDR_B0_FAULT_EN: en_decode = 3'h5;
      `HVB_ADDR_B1_EDGE_EN: en_decode = 3'h6;
      `HVB_ADDR_B1_FAULT_EN: en_decode = 3'h7;
      default: en_decode = 3'h0;
    endcase
  endfunction : en_decode

  // returns {hit, index} for a pending register address
  function automatic logic [2:0] pend_decode(input logic [6:0] addr);
    case (addr)
      `HVB_ADDR_B0_EDGE_PEND: pend_decode = 3'h4;
      `HVB_ADDR_B0_FAULT_PEND: pend_decode = 3'h5;
      `HVB_ADDR_B1_EDGE_PEND: pend_decode = 3'h6;
      `HVB_ADDR_B1_FAULT_PEND: pend_decode = 3'h7;
      default: pend_decode = 3'h0;
    endcase
  endfunction : pend_decode

  // ****************************************
  // decoded addresses, shared by the write and read paths
  // ****************************************
  // one decode per bus keeps the read mux and the write strobes in step
  assign wr_en_dec = en_decode(wr_req.addr);
  assign wr_pend_dec = pend_decode(wr_req.addr);
  assign rd_en_dec = en_decode(rd_addr);
  assign rd_pend_dec = pend_decode(rd_addr);
  assign en_wr_hit = wr_req.wr && wr_en_dec[2];
  assign wr_pend_hit = wr_req.wr && wr_pend_dec[2];

  // ****************************************
  // serial port
  // ****************************************
  // writes land a few cycles after chip select rises, behind the synchronisers
  hvb_spi_slave u_spi (
    .clk(clk),
    .sys_rst(sys_rst),
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr_req(wr_req)
  );

  // ****************************************
  // event vector in register order
  // ****************************************
  assign ev[0] = pin_events.b0_transition;
  assign ev[1] = pin_events.b0_fault;
  assign ev[2] = pin_events.b1_transition;
  assign ev[3] = pin_events.b1_fault;

  // off and fail-safe both force pending flags low on entry
  assign mode_clear = mode_enter && (mode_sel == mode_off || mode_sel == mode_fsp);

  // ****************************************
  // enable registers
  // ****************************************
  // mode entry outranks a serial write landing in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NREG; i++) begin
        en_reg[i] <= `HVB_EN_RESET;
      end
    end else if (mode_enter) begin
      case (mode_sel)
        mode_off: begin
          for (int i = 0; i < NREG; i++) begin
            en_reg[i] <= `HVB_EN_RESET;
          end
        end
        mode_fsp: begin
          en_reg[0] <= `HVB_FSP_EDGE_EN;
          en_reg[1] <= `HVB_FSP_FAULT_EN;
          en_reg[2] <= `HVB_FSP_EDGE_EN;
          en_reg[3] <= `HVB_FSP_FAULT_EN;
        end
        default: begin
          // other modes leave the enables as software set them
        end
      endcase
    end else if (en_wr_hit) begin
      en_reg[wr_en_dec[1:0]] <= wr_req.data;
    end
  end

  // ****************************************
  // pending registers: write one to clear
  // ****************************************
  // clear masks are zero unless a write hits that pending register
  // a zero bit in the written byte leaves its flag alone
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      clr_mask[i] = 8'h00;
      if (wr_pend_hit && wr_pend_dec[1:0] == 2'(i)) begin
        clr_mask[i] = wr_req.data;
      end
    end
  end

  // a new event in the clearing cycle survives: set beats clear
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      if (mode_clear) begin
        pend_next[i] = ev[i];
      end else begin
        pend_next[i] = (pend_reg[i] & ~clr_mask[i]) | ev[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NREG; i++) begin
        pend_reg[i] <= `HVB_PEND_RESET;
      end
    end else begin
      for (int i = 0; i < NREG; i++) begin
        pend_reg[i] <= pend_next[i];
      end
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  // unmapped addresses read zero rather than stalling the frame
  always_comb begin
    if (rd_en_dec[2]) begin
      rd_data = en_reg[rd_en_dec[1:0]];
    end else if (rd_pend_dec[2]) begin
      rd_data = pend_reg[rd_pend_dec[1:0]];
    end else begin
      rd_data = `HVB_UNMAPPED_READ;
    end
  end

  // ****************************************
  // interrupt request
  // ****************************************
  // computed from the registered flags so it never glitches
  // costs one cycle of latency after a flag or enable changes
  always_comb begin
    active_next = 32'h0000_0000;
    for (int i = 0; i < NREG; i++) begin
      // a zero enable bit masks its flag but leaves it pending
      active_next[8*i +: 8] = pend_reg[i] & en_reg[i];
    end
    irq_next = |active_next;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_req <= 1'b0;
      irq_active_vec <= 32'h0000_0000;
    end else begin
      irq_req <= irq_next;
      irq_active_vec <= active_next;
    end
  end
endmodule : hvb_irq_enable_bank

// ---- bench/hvb_bank_properties.sv ----
// checker for the pin interrupt enable bank ports
// assumes: bound onto hvb_irq_enable_bank, one clock domain
`timescale 1ns/10ps
module hvb_bank_properties import hvb_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial pins
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe,
  // mode and events
  input wire logic mode_enter,
  input wire hvb_mode_t mode_sel,
  input wire hvb_pin_events_t pin_events,
  // interrupt
  input wire logic irq_req,
  input wire logic [31:0] irq_active_vec
);
  logic [3:0] cs_cnt;
  logic [3:0] ev_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****
  // quiet streaks; a write lands several cycles after cs rises
  // ****
  always_ff @(posedge clk) begin
    if (sys_rst || !spi_cs_n) cs_cnt <= 4'h0;
    else if (cs_cnt != 4'hf) cs_cnt <= cs_cnt + 4'h1;
  end
  always_ff @(posedge clk) begin
    if (sys_rst || mode_enter || pin_events != '0) ev_cnt <= 4'h0;
    else if (ev_cnt != 4'hf) ev_cnt <= ev_cnt + 4'h1;
  end
  irq_or_a: assert property (irq_req == (|irq_active_vec))
    else $error("irq request differs from active vector");
  rst_quiet_a: assert property (disable iff (1'b0) sys_rst |=> !irq_req && !spi_sdo_oe)
    else $error("outputs not quiet after reset");
  off_clear_a: assert property (mode_enter && mode_sel == mode_off |-> ##2 irq_active_vec == '0)
    else $error("off mode left interrupts active");
  fsp_clear_a: assert property (mode_enter && mode_sel == mode_fsp && pin_events == '0
    |-> ##2 irq_active_vec == '0)
    else $error("fail-safe mode left interrupts active");
  keep_mode_a: assert property (mode_enter && !(mode_sel inside {mode_off, mode_fsp})
    && pin_events == '0 && ev_cnt >= 4'h3 && cs_cnt >= 4'ha |=> ##1 $stable(irq_active_vec))
    else $error("mode entry changed kept bits");
  vec_hold_a: assert property (cs_cnt >= 4'ha && ev_cnt >= 4'h3 |-> $stable(irq_active_vec))
    else $error("active vector moved with no cause");
  no_fall_a: assert property (cs_cnt >= 4'ha && !$past(mode_enter) && !$past(mode_enter, 2)
    |-> ($past(irq_active_vec) & ~irq_active_vec) == '0)
    else $error("pending flag dropped with no clear");
  oe_idle_a: assert property (spi_cs_n && $past(spi_cs_n) && $past(spi_cs_n, 2) |-> !spi_sdo_oe)
    else $error("data out driven while deselected");
  fsp_c: cover property (mode_enter && mode_sel == mode_fsp);
  irq_c: cover property ($rose(irq_req));
  frame_c: cover property ($rose(spi_cs_n));
endmodule : hvb_bank_properties

bind hvb_irq_enable_bank hvb_bank_properties u_props (.clk(clk), .sys_rst(sys_rst),
  .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
  .spi_sdo_oe(spi_sdo_oe), .mode_enter(mode_enter), .mode_sel(mode_sel),
  .pin_events(pin_events), .irq_req(irq_req), .irq_active_vec(irq_active_vec));

// ---- bench/hvb_spi_host_model.sv ----
// serial host model standing in for the microcontroller
// assumes: frames started by the bench; sck idles low outside frames
`timescale 1ns/10ps
module hvb_spi_host_model (
  // clock
  input wire logic clk,
  // serial pins
  output logic sck,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : tick
  // msb first; short nbits gives a truncated frame
  task automatic xfer(input logic [15:0] frame, input int nbits, output logic [7:0] rdata);
    rdata = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      sdi = frame[15 - i];
      tick(3);
      sck = 1'b1;
      tick(6);
      if (i > 7) rdata = {rdata[6:0], sdo};
      sck = 1'b0;
      // hold sdi past the falling edge the device samples on
      tick(3);
    end
    tick(6);
    cs_n = 1'b1;
    // released line shows no stale bit
    sdi = ~sdi;
    tick(12);
  endtask : xfer
endmodule : hvb_spi_host_model

// ---- bench/tb_top.sv ----
// self-checking bench for the pin interrupt enable bank
// assumes: host model drives the serial pins, bench drives events and modes
`timescale 1ns/10ps
module tb_top import hvb_pkg::*; ;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sck, cs_n, sdi, sdo, sdo_oe, irq_req, mode_enter;
  hvb_mode_t mode_sel;
  hvb_pin_events_t pin_events;
  logic [31:0] irq_active_vec;
  logic [6:0] en_a [4] = '{7'h37, 7'h38, 7'h47, 7'h48};
  logic [6:0] pd_a [4] = '{7'h64, 7'h65, 7'h66, 7'h67};
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  hvb_irq_enable_bank uut (.clk(clk), .sys_rst(sys_rst), .spi_sck(sck), .spi_cs_n(cs_n),
    .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .mode_enter(mode_enter),
    .mode_sel(mode_sel), .pin_events(pin_events), .irq_req(irq_req),
    .irq_active_vec(irq_active_vec));
  hvb_spi_host_model host (.clk(clk), .sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  // ****
  // helpers
  // ****
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rw(input logic [6:0] a, input logic ro, input logic [7:0] d,
    output logic [7:0] r);
    host.xfer({a, ro, d}, 16, r);
  endtask : rw
  task automatic pulse(input logic [31:0] ev, input logic me, input hvb_mode_t ms);
    pin_events = ev;
    mode_enter = me;
    mode_sel = ms;
    @(posedge clk);
    #5;
    pin_events = '0;
    mode_enter = 1'b0;
    repeat (3) @(posedge clk);
    #5;
  endtask : pulse
  // event struct reordered into the active vector layout
  function automatic logic [31:0] lay(input hvb_pin_events_t e);
    return {e.b1_fault, e.b1_transition, e.b0_fault, e.b0_transition};
  endfunction : lay
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    logic [7:0] r, v;
    logic [31:0] en, ev, pe;
    int unsigned seed;
    pin_events = '0;
    mode_enter = 1'b0;
    mode_sel = mode_normal;
    seed = $urandom(32'ha841_56e2);
    repeat (4) @(posedge clk);
    #5 sys_rst = 1'b0;
    repeat (3) @(posedge clk);
    #5;
    for (int k = 0; k < 4; k++) begin
      rw(en_a[k], 1'b1, 8'h00, r);
      chk("enable reset", 32'h0000_0000, r);
      for (int j = 0; j < 3; j++) begin
        v = (j == 0) ? 8'hff : (j == 1) ? 8'h00 : 8'($urandom);
        rw(en_a[k], 1'b0, v, r);
        rw(en_a[k], 1'b1, 8'h00, r);
        chk("enable rw", v, r);
      end
    end
    rw(7'h37, 1'b0, 8'hc3, r);
    rw(7'h10, 1'b0, 8'h5a, r);
    rw(7'h10, 1'b1, 8'h00, r);
    chk("unmapped", 32'h0000_0000, r);
    host.xfer({7'h37, 1'b0, 8'h3c}, 15, r);
    rw(7'h37, 1'b1, 8'h3c, r);
    rw(7'h37, 1'b1, 8'h00, r);
    chk("refused write", 32'h0000_00c3, r);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      en = (i == 0) ? 32'h0000_0000 : $urandom;
      ev = (i == 0) ? 32'hffff_ffff : $urandom;
      for (int k = 0; k < 4; k++) rw(en_a[k], 1'b0, en[8*k+:8], r);
      pulse(ev, 1'b0, mode_normal);
      chk("active", en & lay(ev), irq_active_vec);
      chk("irq", 32'(|(en & lay(ev))), 32'(irq_req));
      for (int k = 0; k < 4; k++) begin
        rw(pd_a[k], 1'b1, 8'h00, r);
        chk("pending", lay(ev) >> (8 * k) & 32'h0000_00ff, r);
        rw(pd_a[k], 1'b0, 8'hff, r);
      end
      chk("cleared", 32'h0000_0000, irq_active_vec);
    end
    $display("test events done");
    for (int m = 0; m < 8; m++) begin
      for (int k = 0; k < 4; k++) rw(en_a[k], 1'b0, 8'hff, r);
      pulse(32'hffff_ffff, 1'b0, mode_normal);
      pulse(32'h0000_0000, 1'b1, hvb_mode_t'(3'(m)));
      en = (m == 0) ? 32'h0000_0000 : (m == 7) ? 32'h00aa_00aa : 32'hffff_ffff;
      pe = (m == 0 || m == 7) ? 32'h0000_0000 : 32'hffff_ffff;
      chk("mode active", en & pe, irq_active_vec);
      for (int k = 0; k < 4; k++) begin
        rw(en_a[k], 1'b1, 8'h00, r);
        chk("mode enable", en >> (8 * k) & 32'h0000_00ff, r);
        rw(pd_a[k], 1'b0, 8'hff, r);
      end
    end
    $display("test modes done");
    for (int k = 0; k < 4; k++) rw(en_a[k], 1'b0, 8'hff, r);
    pulse(32'hffff_ffff, 1'b0, mode_normal);
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    #5 sys_rst = 1'b0;
    repeat (3) @(posedge clk);
    #5;
    chk("reset active", 32'h0000_0000, irq_active_vec);
    chk("sdo enable idle", 32'h0000_0000, 32'(sdo_oe));
    for (int k = 0; k < 4; k++) begin
      rw(en_a[k], 1'b1, 8'h00, r);
      chk("reset enable", 32'h0000_0000, r);
      rw(pd_a[k], 1'b1, 8'h00, r);
      chk("reset pending", 32'h0000_0000, r);
    end
    $display("test reset done");
    complete_run();
  end
endmodule : tb_top
